// ==== rtl/ulkst_pkg.sv ====
// Constants shared by the legacy keyboard and mouse trap block.
package ulkst_pkg;

    // Configuration offset and reset value of each trap control copy.
    localparam logic [7:0]  LKM_TRAP_CTRL_OFS = 8'hc0;
    localparam logic [15:0] LKM_TRAP_CTRL_RST = 16'h2000;

    // Bits that software stores in each copy, and bits cleared by writing one.
    localparam logic [15:0] LKM_CTRL_WR_MASK  = 16'h20bf;
    localparam logic [15:0] LKM_W1C_MASK      = 16'h8f00;

    // Field positions in the trap control word.
    localparam int END_PT_FLAG_BIT    = 15;
    localparam int PCI_IRQ_GATE_BIT   = 13;
    localparam int USB_IRQ_FLAG_BIT   = 12;
    localparam int TRAP_FLAG_LSB      = 8;
    localparam int END_PT_SMI_EN_BIT  = 7;
    localparam int PT_ACTIVE_BIT      = 6;
    localparam int PT_EN_BIT          = 5;
    localparam int USB_SMI_EN_BIT     = 4;
    localparam int TRAP_EN_LSB        = 0;

    // Order of the four port traps inside the flag and enable nibbles.
    localparam int TRAP_DATA_RD = 0;
    localparam int TRAP_DATA_WR = 1;
    localparam int TRAP_CMD_RD  = 2;
    localparam int TRAP_CMD_WR  = 3;

    // Legacy controller I/O ports and the gate command sequence.
    localparam logic [15:0] DATA_PORT_ADDR = 16'h0060;
    localparam logic [15:0] CMD_PORT_ADDR  = 16'h0064;
    localparam logic [7:0]  GATE_CMD_BYTE  = 8'hd1;
    localparam int          GATE_DATA_BIT  = 1;
    localparam logic        GATE_RST_VAL   = 1'b1;

    // States of the gate pass-through sequencer.
    typedef enum logic { PT_IDLE, PT_CMD_SEEN } ulkst_pt_state_t;

endpackage

// ==== rtl/ulkst_pt_if.sv ====
// Signals between the trap core and the pass-through sequencer.
`timescale 1ns/1ns
interface ulkst_pt_if;
    logic       cmd_wr;       // Host write to the command port.
    logic       data_wr;      // Host write to the data port.
    logic [7:0] wdata;        // Byte of the host write.
    logic       pt_en;        // Combined pass-through enable.
    logic       evt;          // Some trap or controller event this cycle.
    logic       suppress;     // The current write belongs to the gate sequence.
    logic       active;       // Sequencer is part-way through a sequence.
    logic       end_pending;  // Sequence ended with an event pending.
    logic       gate;         // Address line gate level.

    modport fsm  (input cmd_wr, data_wr, wdata, pt_en, evt,
                  output suppress, active, end_pending, gate);
    modport core (output cmd_wr, data_wr, wdata, pt_en, evt,
                  input suppress, active, end_pending, gate);
endinterface

// ==== rtl/ulkst_ctrl_copy.sv ====
// One controller's own copy of the stored trap control bits.
`timescale 1ns/1ns
module ulkst_ctrl_copy (
    input  wire logic        clk_in,    // Core clock.
    input  wire logic        rst_n_in,  // Synchronous reset, active low.
    input  wire logic        wr_in,     // Write to this copy.
    input  wire logic [1:0]  be_in,     // Byte enables of the write.
    input  wire logic [15:0] wdata_in,  // Write data.
    output logic      [15:0] ctrl_out   // Stored bits of this copy.
);

    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] wmask;

    // Only enabled byte lanes of the stored bits take new data.
    assign wmask    = wr_in ? ({{8{be_in[1]}}, {8{be_in[0]}}} & ulkst_pkg::LKM_CTRL_WR_MASK)
                            : 16'h0000;
    assign ctrl_nxt = (ctrl_r & ~wmask) | (wdata_in & wmask);
    assign ctrl_out = ctrl_r;

    // The copy starts with the controller interrupt gate open.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            ctrl_r <= ulkst_pkg::LKM_TRAP_CTRL_RST;
        else
            ctrl_r <= ctrl_nxt;
    end

endmodule

// ==== rtl/ulkst_pt_fsm.sv ====
// Sequencer that lets the address line gate write pair pass untrapped.
`timescale 1ns/1ns
module ulkst_pt_fsm (
    input  wire logic clk_in,   // Core clock.
    input  wire logic rst_n_in, // Synchronous reset, active low.
    ulkst_pt_if.fsm   pt        // Link to the trap core.
);

    ulkst_pkg::ulkst_pt_state_t state_r;
    ulkst_pkg::ulkst_pt_state_t state_nxt;
    logic pending_r;
    logic pending_nxt;
    logic end_pending_r;
    logic gate_r;
    logic cmd_gate;
    logic finish;
    logic abort;
    logic leave;

    // Recognise the command byte, the closing data write and any break.
    assign cmd_gate    = pt.pt_en && pt.cmd_wr && (pt.wdata == ulkst_pkg::GATE_CMD_BYTE);
    assign finish      = (state_r == ulkst_pkg::PT_CMD_SEEN) && pt.pt_en && pt.data_wr;
    assign abort       = (state_r == ulkst_pkg::PT_CMD_SEEN)
                         && (!pt.pt_en || (pt.cmd_wr && !cmd_gate));
    assign leave       = finish || abort;
    assign pt.suppress = cmd_gate || finish;
    assign pt.active   = (state_r == ulkst_pkg::PT_CMD_SEEN);
    assign pt.end_pending = end_pending_r;
    assign pt.gate     = gate_r;
    assign pending_nxt = (leave || (state_r == ulkst_pkg::PT_IDLE)) ? 1'b0
                                                                   : (pending_r || pt.evt);

    // Next state: command write opens, data write or a break closes.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ulkst_pkg::PT_IDLE:
                if (cmd_gate)
                    state_nxt = ulkst_pkg::PT_CMD_SEEN;
            ulkst_pkg::PT_CMD_SEEN:
                if (leave)
                    state_nxt = ulkst_pkg::PT_IDLE;
            default:
                state_nxt = ulkst_pkg::PT_IDLE;
        endcase
    end

    // State, pending event, end report and gate level.
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r       <= ulkst_pkg::PT_IDLE;
            pending_r     <= 1'b0;
            end_pending_r <= 1'b0;
            gate_r        <= ulkst_pkg::GATE_RST_VAL;
        end
        else
        begin
            state_r       <= state_nxt;
            pending_r     <= pending_nxt;
            end_pending_r <= leave && (pending_r || pt.evt);
            gate_r        <= finish ? pt.wdata[ulkst_pkg::GATE_DATA_BIT] : gate_r;
        end
    end

    default clocking fsm_cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence gate_cmd_s;
        (state_r == ulkst_pkg::PT_IDLE) && cmd_gate;
    endsequence

    sequence gate_data_s;
        pt.active && pt.pt_en && pt.data_wr;
    endsequence

    gate_start_a: assert property (gate_cmd_s |=> pt.active)
        else $error("Gate command write did not start the sequence.");
    gate_finish_a: assert property (gate_data_s |=> !pt.active)
        else $error("Gate data write did not end the sequence.");
    gate_level_a: assert property (gate_data_s |=> pt.gate == $past(pt.wdata[1]))
        else $error("Gate level does not follow the data write.");
    pt_disable_a: assert property ((pt.active && !pt.pt_en) |=> !pt.active)
        else $error("Sequence survived the enable being cleared.");

endmodule

// ==== rtl/usb_legacy_kbd_smi_trap.sv ====
// Legacy keyboard and mouse trap block with pass-through and interrupt logic.
//
// Operation
// - Each controller keeps its own copy; enables OR together, status is shared.
// - End-of-pass-through flag sets when a sequence ends pending; write one clears.
// - Bit 13 gates each controller's PCI interrupt and resets to one.
// - Bit 12 shows this controller's raw interrupt, before the bit 13 gate.
// - Writing one to bit 12 does nothing; software clears it inside the controller.
// - Bit 11 latches on command port writes regardless of enable; write one clears.
// - Bit 10 latches on command port reads regardless of enable; write one clears.
// - Bit 9 latches on data port writes regardless of enable; write one clears.
// - Bit 8 latches on data port reads regardless of enable; write one clears.
// - With bit 5 set the gate write sequence sets no trap flag.
// - Bit 7 lets the end-of-pass-through flag raise the management interrupt.
// - Bit 6 reads one while a gate sequence is part-way through.
// - Enable bits 3 to 0 let flags 11 to 8 raise the interrupt.
// - Enable bit 4 lets a controller interrupt raise the interrupt.
`timescale 1ns/1ns
module usb_legacy_kbd_smi_trap #(
    parameter int N_FUNC = 3,  // Number of host controller functions.
    parameter int FUNC_W = 2   // Width of the function select.
) (
    input  wire logic              REF_CLK_IN,          // Core clock, 100 MHz.
    input  wire logic              RESETN_IN,           // Synchronous reset, active low.
    input  wire logic              CFG_WR_IN,           // Configuration write strobe.
    input  wire logic              CFG_RD_IN,           // Configuration read strobe.
    input  wire logic [FUNC_W-1:0] CFG_FUNC_IN,         // Addressed controller function.
    input  wire logic [7:0]        CFG_ADDR_IN,         // Configuration byte offset.
    input  wire logic [1:0]        CFG_BE_IN,           // Byte enables of the write.
    input  wire logic [15:0]       CFG_WDATA_IN,        // Configuration write data.
    output logic      [15:0]       CFG_RDATA_OUT,       // Registered read data.
    output logic                   CFG_RVALID_OUT,      // Read data valid pulse.
    input  wire logic              IO_RD_IN,            // Host I/O read cycle.
    input  wire logic              IO_WR_IN,            // Host I/O write cycle.
    input  wire logic [15:0]       IO_ADDR_IN,          // Host I/O address.
    input  wire logic [7:0]        IO_WDATA_IN,         // Host I/O write byte.
    input  wire logic [N_FUNC-1:0] USB_IRQ_IN,          // Raw controller interrupts.
    output logic      [N_FUNC-1:0] PCI_IRQ_OUT,         // Gated controller interrupts.
    output logic                   SYS_MGMT_IRQ_N_OUT,  // Management interrupt, active low.
    output logic                   ADDR_LINE_GATE_OUT   // Address line gate level.
);

    // Control copies, their combined enables and the shared status.
    logic [15:0]       ctrl_q [N_FUNC];
    logic [15:0]       en_or;
    logic [N_FUNC-1:0] pci_gate;
    logic [3:0]        flags_r;
    logic [3:0]        flags_nxt;
    logic              end_flag_r;
    logic              end_flag_nxt;
    logic              smi_n_r;
    logic              smi_cond;
    logic [N_FUNC-1:0] pci_irq_r;
    logic [15:0]       rdata_r;
    logic [15:0]       rdata_nxt;
    logic              rvalid_r;

    // Decode of the configuration and host I/O cycles.
    wire               reg_hit;
    wire               reg_wr;
    wire [15:0]        lane_mask;
    wire [15:0]        w1c_clr;
    wire               data_hit;
    wire               cmd_hit;
    wire [3:0]         trap_evt;
    wire [15:0]        ctrl_sel;
    wire               usb_sel;
    wire [15:0]        rd_word;
    wire               kept_wr;

    ulkst_pt_if pt_bus ();

    // Address decode of the trap control word for an existing function.
    assign reg_hit   = (CFG_ADDR_IN == ulkst_pkg::LKM_TRAP_CTRL_OFS)
                       && (int'(CFG_FUNC_IN) < N_FUNC);
    assign reg_wr    = CFG_WR_IN && reg_hit;
    assign lane_mask = {{8{CFG_BE_IN[1]}}, {8{CFG_BE_IN[0]}}};
    assign w1c_clr   = reg_wr ? (CFG_WDATA_IN & lane_mask & ulkst_pkg::LKM_W1C_MASK)
                              : 16'h0000;

    // One stored copy per controller; each sees only writes aimed at it.
    genvar f;
    generate
        for (f = 0; f < N_FUNC; f++)
        begin : g_func
            ulkst_ctrl_copy u_copy (
                .clk_in   (REF_CLK_IN),
                .rst_n_in (RESETN_IN),
                .wr_in    (reg_wr && (CFG_FUNC_IN == FUNC_W'(f))),
                .be_in    (CFG_BE_IN),
                .wdata_in (CFG_WDATA_IN),
                .ctrl_out (ctrl_q[f])
            );
            assign pci_gate[f] = ctrl_q[f][ulkst_pkg::PCI_IRQ_GATE_BIT];
        end
    endgenerate

    // Enable bits of all copies act together.
    always_comb
    begin
        en_or = 16'h0000;
        for (int i = 0; i < N_FUNC; i++)
            en_or = en_or | ctrl_q[i];
    end

    // Host cycles to the two legacy ports, less the gate sequence writes.
    assign data_hit = (IO_ADDR_IN == ulkst_pkg::DATA_PORT_ADDR);
    assign cmd_hit  = (IO_ADDR_IN == ulkst_pkg::CMD_PORT_ADDR);
    assign trap_evt[ulkst_pkg::TRAP_DATA_RD] = IO_RD_IN && data_hit;
    assign kept_wr  = IO_WR_IN && !pt_bus.suppress;
    assign trap_evt[ulkst_pkg::TRAP_DATA_WR] = kept_wr && data_hit;
    assign trap_evt[ulkst_pkg::TRAP_CMD_RD]  = IO_RD_IN && cmd_hit;
    assign trap_evt[ulkst_pkg::TRAP_CMD_WR]  = kept_wr && cmd_hit;

    // Feed the sequencer with host writes and pending events.
    assign pt_bus.cmd_wr  = IO_WR_IN && cmd_hit;
    assign pt_bus.data_wr = IO_WR_IN && data_hit;
    assign pt_bus.wdata   = IO_WDATA_IN;
    assign pt_bus.pt_en   = en_or[ulkst_pkg::PT_EN_BIT];
    assign pt_bus.evt     = (|trap_evt) || (|USB_IRQ_IN);

    ulkst_pt_fsm u_pt_fsm (
        .clk_in   (REF_CLK_IN),
        .rst_n_in (RESETN_IN),
        .pt       (pt_bus)
    );

    // Shared flags: a new event wins over a clear in the same cycle.
    assign flags_nxt    = (flags_r & ~w1c_clr[ulkst_pkg::TRAP_FLAG_LSB +: 4]) | trap_evt;
    assign end_flag_nxt = (end_flag_r && !w1c_clr[ulkst_pkg::END_PT_FLAG_BIT])
                          || pt_bus.end_pending;

    // Management interrupt condition from flags and their combined enables.
    assign smi_cond = (|(flags_r & en_or[ulkst_pkg::TRAP_EN_LSB +: 4]))
                      || ((|USB_IRQ_IN) && en_or[ulkst_pkg::USB_SMI_EN_BIT])
                      || (end_flag_r && en_or[ulkst_pkg::END_PT_SMI_EN_BIT]);

    // Read word of the addressed copy; bit 12 is the live raw interrupt.
    assign ctrl_sel = ctrl_q[CFG_FUNC_IN];
    assign usb_sel  = USB_IRQ_IN[CFG_FUNC_IN];
    assign rd_word  = {end_flag_r, 1'b0, ctrl_sel[ulkst_pkg::PCI_IRQ_GATE_BIT],
                       usb_sel, flags_r, ctrl_sel[ulkst_pkg::END_PT_SMI_EN_BIT],
                       pt_bus.active, ctrl_sel[ulkst_pkg::PT_EN_BIT:0]};
    assign rdata_nxt = (CFG_RD_IN && reg_hit) ? rd_word : 16'h0000;

    // Status flags and the registered outputs.
    always_ff @(posedge REF_CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            flags_r    <= 4'h0;
            end_flag_r <= 1'b0;
            smi_n_r    <= 1'b1;
            pci_irq_r  <= '0;
            rdata_r    <= 16'h0000;
            rvalid_r   <= 1'b0;
        end
        else
        begin
            flags_r    <= flags_nxt;
            end_flag_r <= end_flag_nxt;
            smi_n_r    <= !smi_cond;
            pci_irq_r  <= USB_IRQ_IN & pci_gate;
            rdata_r    <= rdata_nxt;
            rvalid_r   <= CFG_RD_IN;
        end
    end

    assign CFG_RDATA_OUT      = rdata_r;
    assign CFG_RVALID_OUT     = rvalid_r;
    assign PCI_IRQ_OUT        = pci_irq_r;
    assign SYS_MGMT_IRQ_N_OUT = smi_n_r;
    assign ADDR_LINE_GATE_OUT = pt_bus.gate;

    // Checks on flags, interrupt output and read data.
    default clocking top_cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence cmd_wr_trap_s;
        IO_WR_IN && cmd_hit && !pt_bus.suppress;
    endsequence

    sequence end_pending_s;
        pt_bus.end_pending;
    endsequence

    flag_cmd_wr_a: assert property (cmd_wr_trap_s |=> flags_r[3])
        else $error("Command port write did not latch its flag.");
    flag_data_rd_a: assert property ((IO_RD_IN && data_hit) |=> flags_r[0])
        else $error("Data port read did not latch its flag.");
    flag_clear_a: assert property ((flags_r[1] && w1c_clr[9] && !trap_evt[1])
                                   |=> !flags_r[1])
        else $error("Write of one did not clear the data write flag.");
    pt_quiet_a: assert property ((pt_bus.suppress && !reg_wr) |=> $stable(flags_r))
        else $error("Gate sequence write changed a trap flag.");
    end_flag_a: assert property (end_pending_s |=> end_flag_r)
        else $error("Sequence end with pending event did not set its flag.");
    smi_assert_a: assert property (smi_cond |=> !SYS_MGMT_IRQ_N_OUT)
        else $error("Enabled flag did not assert the management interrupt.");
    smi_release_a: assert property (!smi_cond |=> SYS_MGMT_IRQ_N_OUT)
        else $error("Management interrupt stayed asserted with no enabled flag.");
    end_smi_a: assert property ((end_flag_r && en_or[7]) |=> !SYS_MGMT_IRQ_N_OUT)
        else $error("Pass-through end did not raise the management interrupt.");
    pci_gate_a: assert property ((USB_IRQ_IN[0] && !ctrl_q[0][13])
                                 |=> !PCI_IRQ_OUT[0])
        else $error("Controller interrupt passed a closed gate.");
    raw_usb_read_a: assert property ((CFG_RD_IN && reg_hit && CFG_FUNC_IN == '0)
                                     |=> CFG_RDATA_OUT[12] == $past(USB_IRQ_IN[0]))
        else $error("Bit 12 does not show the raw controller interrupt.");
    active_read_a: assert property ((CFG_RD_IN && reg_hit)
                                    |=> CFG_RDATA_OUT[6] == $past(pt_bus.active))
        else $error("Bit 6 does not show the pass-through state.");

endmodule

// ==== sim/ulkst_host_model.sv ====
// Host processor model that issues legacy port cycles and decodes trap causes.
`timescale 1ns/1ns
module ulkst_host_model (
    input  wire logic        clk_in,    // Core clock.
    output logic             rd_out,    // Host I/O read cycle.
    output logic             wr_out,    // Host I/O write cycle.
    output logic      [15:0] addr_out,  // Host I/O address.
    output logic      [7:0]  wdata_out  // Host I/O write byte.
);
    // The bus starts idle with no cycle in flight.
    initial
    begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 16'h0000;
        wdata_out = 8'h00;
    end

    // One I/O cycle held across one rising edge, then the lines are scrambled.
    task automatic io_cycle(input logic wr, input logic [15:0] addr, input logic [7:0] data);
        @(negedge clk_in);
        rd_out = !wr;
        wr_out = wr;
        addr_out = addr;
        wdata_out = data;
        @(negedge clk_in);
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = ~addr;
        wdata_out = ~data;
    endtask

    // The handler masks the flags with their enables to find the real cause.
    function automatic logic [4:0] trap_cause(input logic [15:0] word, input logic [15:0] en);
        return {word[12] & en[4], word[11:8] & en[3:0]};
    endfunction
endmodule

// ==== sim/usb_legacy_kbd_smi_trap_test.sv ====
// Self-checking bench for the legacy keyboard and mouse trap block.
`timescale 1ns/1ns
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: %s", $time, m); end end
module usb_legacy_kbd_smi_trap_test;
    localparam logic [7:0]  OFS  = ulkst_pkg::LKM_TRAP_CTRL_OFS;
    localparam logic [15:0] CMD  = ulkst_pkg::CMD_PORT_ADDR;
    localparam logic [15:0] DATA = ulkst_pkg::DATA_PORT_ADDR;
    localparam logic [7:0]  GCMD = ulkst_pkg::GATE_CMD_BYTE;
    logic        ref_clk, resetn, cfg_wr, cfg_rd, io_rd, io_wr, smi_n, gate, rvalid;
    logic [1:0]  cfg_func, cfg_be;
    logic [7:0]  cfg_addr, io_wdata;
    logic [15:0] cfg_wdata, rdata, io_addr, rd_word;
    logic [2:0]  usb_irq, pci_irq;
    int          fail_count, comparisons;

    usb_legacy_kbd_smi_trap i_usb_legacy_kbd_smi_trap (
        .REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .CFG_WR_IN(cfg_wr), .CFG_RD_IN(cfg_rd),
        .CFG_FUNC_IN(cfg_func), .CFG_ADDR_IN(cfg_addr), .CFG_BE_IN(cfg_be),
        .CFG_WDATA_IN(cfg_wdata), .CFG_RDATA_OUT(rdata), .CFG_RVALID_OUT(rvalid),
        .IO_RD_IN(io_rd), .IO_WR_IN(io_wr), .IO_ADDR_IN(io_addr), .IO_WDATA_IN(io_wdata),
        .USB_IRQ_IN(usb_irq), .PCI_IRQ_OUT(pci_irq), .SYS_MGMT_IRQ_N_OUT(smi_n),
        .ADDR_LINE_GATE_OUT(gate));
    ulkst_host_model i_ulkst_host_model (
        .clk_in(ref_clk), .rd_out(io_rd), .wr_out(io_wr), .addr_out(io_addr),
        .wdata_out(io_wdata));

    // Free-running 100 MHz clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Configuration write of one word to the trap control copy of function f.
    task automatic cfg_write(input logic [1:0] f, input logic [1:0] be, input logic [15:0] d);
        @(negedge ref_clk);
        cfg_wr = 1'b1;
        cfg_func = f;
        cfg_addr = OFS;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
    endtask

    // Configuration read; the answer is judged under a mask one cycle later.
    task automatic cfg_read(input logic [1:0] f, input logic [7:0] a, input logic [15:0] e,
                            input logic [15:0] m);
        @(negedge ref_clk);
        cfg_rd = 1'b1;
        cfg_func = f;
        cfg_addr = a;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        rd_word = rdata;
        `CHK(rvalid, 1'b1, "read valid missing")
        `CHK(rd_word & m, e & m, "read word wrong")
    endtask

    // Reset values and unmapped places.
    task automatic t_reset();
        `CHK(smi_n, 1'b1, "irq not idle")
        `CHK(gate, 1'b1, "gate not idle")
        for (int f = 0; f < 3; f++)
            cfg_read(2'(f), OFS, 16'h2000, 16'hffff);
        cfg_read(2'd3, OFS, 16'h0000, 16'hffff);
        cfg_read(2'd0, 8'hc4, 16'h0000, 16'hffff);
    endtask

    // Port traps latch without enables, then each enable raises the interrupt.
    task automatic t_traps();
        logic [4:0] cause;
        for (int i = 0; i < 4; i++)
            i_ulkst_host_model.io_cycle(i[0], i[1] ? CMD : DATA, 8'h00);
        wait_cyc(2);
        `CHK(smi_n, 1'b1, "irq without enable")
        cfg_read(2'd2, OFS, 16'h2f00, 16'hffff);
        cfg_write(2'd0, 2'b10, 16'h2f00);
        cfg_read(2'd1, OFS, 16'h2000, 16'hffff);
        for (int i = 0; i < 4; i++)
        begin
            cfg_write(2'(i % 3), 2'b01, 16'(1 << i));
            i_ulkst_host_model.io_cycle(i[0], i[1] ? CMD : DATA, 8'h00);
            wait_cyc(2);
            `CHK(smi_n, 1'b0, "trap irq missing")
            cfg_read(2'((i + 1) % 3), OFS, 16'(16'h2000 | (1 << (8 + i))), 16'hffff);
            cause = i_ulkst_host_model.trap_cause(rd_word, 16'(1 << i));
            `CHK(cause, 5'(1 << i), "cause")
            cfg_write(2'((i + 2) % 3), 2'b10, 16'hff00);
            wait_cyc(2);
            `CHK(smi_n, 1'b1, "irq not cleared")
            cfg_write(2'(i % 3), 2'b01, 16'h0000);
        end
    endtask

    // Controller interrupts: raw view, PCI gate and management enable.
    task automatic t_usb();
        usb_irq = 3'b010;
        wait_cyc(2);
        `CHK(pci_irq, 3'b010, "pci irq not passed")
        `CHK(smi_n, 1'b1, "usb irq not masked")
        cfg_write(2'd1, 2'b10, 16'h3000);
        cfg_read(2'd1, OFS, 16'h3000, 16'hffff);
        cfg_read(2'd0, OFS, 16'h2000, 16'hffff);
        cfg_write(2'd0, 2'b01, 16'h0010);
        cfg_write(2'd1, 2'b10, 16'h0000);
        wait_cyc(2);
        `CHK(smi_n, 1'b0, "usb irq missing")
        `CHK(pci_irq, 3'b000, "pci irq not gated")
        cfg_read(2'd1, OFS, 16'h1000, 16'hffff);
        usb_irq = 3'b000;
        wait_cyc(2);
        `CHK(smi_n, 1'b1, "usb irq stuck")
        cfg_write(2'd0, 2'b01, 16'h0000);
        cfg_write(2'd1, 2'b10, 16'h2000);
    endtask

    // Gate pass-through: clean pass, pending event, abort and disable.
    task automatic t_pass();
        cfg_write(2'd2, 2'b01, 16'h0020);
        i_ulkst_host_model.io_cycle(1'b1, CMD, GCMD);
        cfg_read(2'd2, OFS, 16'h2060, 16'hffff);
        i_ulkst_host_model.io_cycle(1'b1, DATA, 8'h00);
        wait_cyc(2);
        `CHK(gate, 1'b0, "gate not low")
        cfg_read(2'd0, OFS, 16'h2000, 16'hffff);
        i_ulkst_host_model.io_cycle(1'b1, CMD, GCMD);
        usb_irq = 3'b001;
        wait_cyc(1);
        usb_irq = 3'b000;
        i_ulkst_host_model.io_cycle(1'b1, DATA, 8'h02);
        wait_cyc(2);
        `CHK(gate, 1'b1, "gate not high")
        `CHK(smi_n, 1'b1, "end irq not masked")
        cfg_read(2'd1, OFS, 16'ha000, 16'hffff);
        cfg_write(2'd0, 2'b01, 16'h0080);
        wait_cyc(2);
        `CHK(smi_n, 1'b0, "end irq missing")
        cfg_write(2'd1, 2'b10, 16'ha000);
        wait_cyc(2);
        `CHK(smi_n, 1'b1, "end flag stuck")
        cfg_write(2'd0, 2'b01, 16'h0000);
        i_ulkst_host_model.io_cycle(1'b1, CMD, GCMD);
        i_ulkst_host_model.io_cycle(1'b1, CMD, 8'h00);
        cfg_read(2'd2, OFS, 16'h2820, 16'h7fff);
        cfg_write(2'd2, 2'b10, 16'hbf00);
        i_ulkst_host_model.io_cycle(1'b1, CMD, GCMD);
        cfg_write(2'd2, 2'b01, 16'h0000);
        // The sequencer sees the dropped enable one edge after the write lands.
        wait_cyc(1);
        cfg_read(2'd2, OFS, 16'h2000, 16'h7fff);
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Cuts a hang short well after the 170 or so cycles the tests need.
    initial
    begin
        #20000;
        fail_count++;
        end_sim();
    end

    // Main sequence: reset for 20 cycles, then every scenario in turn.
    initial
    begin
        resetn = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_func = 2'd0;
        cfg_addr = OFS;
        cfg_be = 2'b00;
        cfg_wdata = 16'h0000;
        usb_irq = 3'b000;
        fail_count = 0;
        comparisons = 0;
        wait_cyc(20);
        resetn = 1'b1;
        t_reset();
        t_traps();
        t_usb();
        t_pass();
        end_sim();
    end
endmodule
